// ### orbt_pkg.sv
package orbt_pkg;
    // widths and depths
    localparam int DATA_W = 8;
    localparam int FIFO_DEPTH = 16;
    localparam int FIFO_PTR_W = 4;
    localparam int FIFO_CNT_W = 5;
    localparam int BUS_ADDR_W = 8;
    localparam int BUS_DATA_W = 32;

    // register byte offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_STATUS = 8'h04;
    localparam logic [7:0] OFS_A_STORE = 8'h08;
    localparam logic [7:0] OFS_B_STORE = 8'h0C;
    localparam logic [7:0] OFS_LOG = 8'h10;

    // control field positions
    localparam int CTRL_LOG_EN_BIT = 0;
    localparam int CTRL_CAP_A_BIT = 1;
    localparam int CTRL_CAP_B_BIT = 2;
    localparam int CTRL_CLR_OVR_BIT = 3;

    // status field positions
    localparam int ST_A_OE_BIT = 0;
    localparam int ST_B_OE_BIT = 1;
    localparam int ST_EMPTY_BIT = 2;
    localparam int ST_FULL_BIT = 3;
    localparam int ST_OVR_BIT = 4;
    localparam int ST_A_LOADED_BIT = 5;
    localparam int ST_B_LOADED_BIT = 6;
    localparam int ST_COUNT_LSB = 8;

    // log word field positions
    localparam int LOG_SIDE_BIT = 8;
    localparam int LOG_VALID_BIT = 31;

    // reset values
    localparam logic CTRL_LOG_EN_RST = 1'b0;
    localparam logic CAP_CLK_Q_RST = 1'b1;
    localparam logic [7:0] PORT_OUT_RST = 8'h00;
    localparam logic [31:0] READDATA_RST = 32'h0000_0000;

    // bus handshake states
    typedef enum logic [1:0] {
        ORBT_BUS_IDLE = 2'b01,
        ORBT_BUS_ACK = 2'b10
    } orbt_bus_state_t;

    // control pins taken together
    typedef struct packed {
        logic b_en;
        logic a_en_n;
        logic b_sel;
        logic a_sel;
    } orbt_ctl_t;

    // one captured word for the log
    typedef struct packed {
        logic side_b;
        logic [DATA_W-1:0] data;
    } orbt_log_t;
endpackage

// ### orbt_mem.sv
`timescale 1ns/10ps
module orbt_mem #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 16,
    parameter int AW = 4
) (
    // clock
    input wire logic clk_sys,
    // write side
    input wire logic wr_en,
    input wire logic [AW-1:0] wr_addr,
    input wire logic [WIDTH-1:0] wr_data,
    // read side
    input wire logic [AW-1:0] rd_addr,
    output logic [WIDTH-1:0] rd_data
);
    logic [WIDTH-1:0] mem_r [DEPTH];

    always_ff @(posedge clk_sys) begin
        if (wr_en) begin
            mem_r[wr_addr] <= wr_data;
        end
    end

    always_ff @(posedge clk_sys) begin
        rd_data <= mem_r[rd_addr];
    end
endmodule

// ### orbt_fifo.sv
`timescale 1ns/10ps
module orbt_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 16,
    parameter int AW = 4,
    parameter int CW = 5
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic resetn,
    // fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data,
    output logic out_settled,
    // fill level
    output logic [CW-1:0] count,
    output logic full,
    output logic empty
);
    logic [AW-1:0] wr_ptr_r;
    logic [AW-1:0] rd_ptr_r;
    logic [CW-1:0] count_r;
    logic stale_r;
    logic push;
    logic pop;

    assign full = (count_r == CW'(DEPTH));
    assign empty = (count_r == '0);
    assign in_ready = !full;
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    // head word is read through a register, so it lags one cycle
    assign out_settled = !stale_r;
    assign out_valid = !empty && !stale_r;
    assign count = count_r;

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            count_r <= '0;
            stale_r <= 1'b1;
        end else begin
            if (push) begin
                wr_ptr_r <= wr_ptr_r + AW'(1);
            end
            if (pop) begin
                rd_ptr_r <= rd_ptr_r + AW'(1);
            end
            count_r <= count_r + CW'(push) - CW'(pop);
            stale_r <= pop || (push && wr_ptr_r == rd_ptr_r);
        end
    end

    orbt_mem #(.WIDTH(WIDTH), .DEPTH(DEPTH), .AW(AW)) u_mem (
        .clk_sys(clk_sys),
        .wr_en(push),
        .wr_addr(wr_ptr_r),
        .wr_data(in_data),
        .rd_addr(rd_ptr_r),
        .rd_data(out_data)
    );
endmodule

// ### orbt_xcvr.sv
// Behaviour
// - data pass between the two 8-bit ports A and B with no bit inverted.
// - a rising A capture clock loads port A into the A register, likewise B.
// - B is driven only with its enable high, A only with its enable low.
// - with both ports undriven each register holds unless its clock rises or software sets its capture bit in the control register.
// - driven B with its select low follows live port A.
// - driven B with its select high shows the A register, not live A.
// - a capture on A while B shows the A register shows the new value.
// - driven A with its select low follows live port B.
// - driven A with its select high shows the B register, kept up to date.
// - both enables active and both selects high drive both from registers.
// - capture clocks are not gated by enables or selects in any mode.
// - both driven with both selects low loops each port onto the other.
// - data passing in real time can be stored in either or both registers.
`timescale 1ns/10ps
module orbt_xcvr (
    // system
    input wire logic clk_sys,
    input wire logic resetn,
    // port a
    input wire logic [7:0] a_in,
    output logic [7:0] a_out,
    output logic a_oe,
    // port b
    input wire logic [7:0] b_in,
    output logic [7:0] b_out,
    output logic b_oe,
    // transceiver controls
    input wire logic b_side_drive_enable,
    input wire logic a_side_drive_enable_low,
    input wire logic b_side_source_select,
    input wire logic a_side_source_select,
    input wire logic a_register_capture_clock,
    input wire logic b_register_capture_clock,
    // avalon-mm slave
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest
);
    function automatic logic reg_hit(input logic [7:0] addr,
                                     input logic [7:0] ofs);
        reg_hit = (addr == ofs);
    endfunction

    orbt_pkg::orbt_ctl_t ctl;
    logic [7:0] a_storage_register;
    logic [7:0] b_storage_register;
    logic [7:0] a_storage_nxt;
    logic [7:0] b_storage_nxt;
    logic a_clk_q_r;
    logic b_clk_q_r;
    logic a_rise;
    logic b_rise;
    logic a_cap;
    logic b_cap;
    logic a_loaded_r;
    logic b_loaded_r;
    logic [7:0] a_out_r;
    logic [7:0] b_out_r;
    logic a_oe_r;
    logic b_oe_r;
    orbt_pkg::orbt_bus_state_t bus_state_r;
    orbt_pkg::orbt_bus_state_t bus_state_nxt;
    logic waitreq_r;
    logic [31:0] readdata_r;
    logic [31:0] readdata_nxt;
    logic bus_req;
    logic bus_go;
    logic bus_done;
    logic wr_done;
    logic ctrl_wr;
    logic log_en_r;
    logic ovr_r;
    logic sw_cap_a;
    logic sw_cap_b;
    logic clr_ovr;
    orbt_pkg::orbt_log_t pend_a_r;
    orbt_pkg::orbt_log_t pend_b_r;
    logic pend_a_v_r;
    logic pend_b_v_r;
    orbt_pkg::orbt_log_t fifo_in;
    orbt_pkg::orbt_log_t fifo_out;
    logic fifo_in_valid;
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic fifo_settled;
    logic fifo_pop;
    logic take_a;
    logic take_b;
    logic [4:0] fifo_count;
    logic fifo_full;
    logic fifo_empty;

    assign ctl = '{b_en: b_side_drive_enable,
                   a_en_n: a_side_drive_enable_low,
                   b_sel: b_side_source_select,
                   a_sel: a_side_source_select};

    // outputs straight from flops
    assign a_out = a_out_r;
    assign b_out = b_out_r;
    assign a_oe = a_oe_r;
    assign b_oe = b_oe_r;
    assign avs_readdata = readdata_r;
    assign avs_waitrequest = waitreq_r;

    // capture clock edge detect, ungated by enables or selects
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            a_clk_q_r <= orbt_pkg::CAP_CLK_Q_RST;
            b_clk_q_r <= orbt_pkg::CAP_CLK_Q_RST;
        end else begin
            a_clk_q_r <= a_register_capture_clock;
            b_clk_q_r <= b_register_capture_clock;
        end
    end

    assign a_rise = a_register_capture_clock && !a_clk_q_r;
    assign b_rise = b_register_capture_clock && !b_clk_q_r;
    assign a_cap = a_rise || sw_cap_a;
    assign b_cap = b_rise || sw_cap_b;

    // storage registers, no reset
    assign a_storage_nxt = a_cap ? a_in : a_storage_register;
    assign b_storage_nxt = b_cap ? b_in : b_storage_register;

    always_ff @(posedge clk_sys) begin
        a_storage_register <= a_storage_nxt;
        b_storage_register <= b_storage_nxt;
    end

    // loaded flags
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            a_loaded_r <= 1'b0;
            b_loaded_r <= 1'b0;
        end else begin
            a_loaded_r <= a_loaded_r || a_cap;
            b_loaded_r <= b_loaded_r || b_cap;
        end
    end

    // port drivers
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            a_oe_r <= 1'b0;
            b_oe_r <= 1'b0;
            a_out_r <= orbt_pkg::PORT_OUT_RST;
            b_out_r <= orbt_pkg::PORT_OUT_RST;
        end else begin
            b_oe_r <= ctl.b_en;
            a_oe_r <= !ctl.a_en_n;
            // live path non-inverting, stored path shows new capture
            b_out_r <= ctl.b_sel ? a_storage_nxt : a_in;
            a_out_r <= ctl.a_sel ? b_storage_nxt : b_in;
        end
    end

    // bus handshake: one wait cycle, more while a log read waits for a settled fifo head, then a single ack cycle
    assign bus_req = avs_read || avs_write;
    assign bus_go = bus_req && !(avs_read && reg_hit(avs_address,
                    orbt_pkg::OFS_LOG) && !fifo_settled);
    assign bus_done = (bus_state_r == orbt_pkg::ORBT_BUS_ACK) && bus_req;
    assign wr_done = bus_done && avs_write;
    assign ctrl_wr = wr_done && avs_byteenable[0]
                     && reg_hit(avs_address, orbt_pkg::OFS_CTRL);
    assign sw_cap_a = ctrl_wr
                      && avs_writedata[orbt_pkg::CTRL_CAP_A_BIT];
    assign sw_cap_b = ctrl_wr
                      && avs_writedata[orbt_pkg::CTRL_CAP_B_BIT];
    assign clr_ovr = ctrl_wr && avs_writedata[orbt_pkg::CTRL_CLR_OVR_BIT];
    assign fifo_pop = bus_done && avs_read
                      && reg_hit(avs_address, orbt_pkg::OFS_LOG);

    always_comb begin
        bus_state_nxt = bus_state_r;
        case (bus_state_r)
            orbt_pkg::ORBT_BUS_IDLE: begin
                if (bus_go) begin
                    bus_state_nxt = orbt_pkg::ORBT_BUS_ACK;
                end
            end
            orbt_pkg::ORBT_BUS_ACK: begin
                bus_state_nxt = orbt_pkg::ORBT_BUS_IDLE;
            end
            default: begin
                bus_state_nxt = orbt_pkg::ORBT_BUS_IDLE;
            end
        endcase
    end

    always_comb begin
        readdata_nxt = '0;
        if (reg_hit(avs_address, orbt_pkg::OFS_CTRL)) begin
            readdata_nxt[orbt_pkg::CTRL_LOG_EN_BIT] = log_en_r;
        end else if (reg_hit(avs_address, orbt_pkg::OFS_STATUS)) begin
            readdata_nxt[orbt_pkg::ST_A_OE_BIT] = a_oe_r;
            readdata_nxt[orbt_pkg::ST_B_OE_BIT] = b_oe_r;
            readdata_nxt[orbt_pkg::ST_EMPTY_BIT] = fifo_empty;
            readdata_nxt[orbt_pkg::ST_FULL_BIT] = fifo_full;
            readdata_nxt[orbt_pkg::ST_OVR_BIT] = ovr_r;
            readdata_nxt[orbt_pkg::ST_A_LOADED_BIT] = a_loaded_r;
            readdata_nxt[orbt_pkg::ST_B_LOADED_BIT] = b_loaded_r;
            readdata_nxt[orbt_pkg::ST_COUNT_LSB +: 5] = fifo_count;
        end else if (reg_hit(avs_address, orbt_pkg::OFS_A_STORE)) begin
            readdata_nxt[7:0] = a_storage_register;
        end else if (reg_hit(avs_address, orbt_pkg::OFS_B_STORE)) begin
            readdata_nxt[7:0] = b_storage_register;
        end else if (reg_hit(avs_address, orbt_pkg::OFS_LOG)) begin
            readdata_nxt[orbt_pkg::LOG_VALID_BIT] = fifo_out_valid;
            readdata_nxt[orbt_pkg::LOG_SIDE_BIT] = fifo_out_valid
                                                   && fifo_out.side_b;
            readdata_nxt[7:0] = fifo_out_valid ? fifo_out.data : 8'h00;
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            bus_state_r <= orbt_pkg::ORBT_BUS_IDLE;
            waitreq_r <= 1'b1;
            readdata_r <= orbt_pkg::READDATA_RST;
        end else begin
            bus_state_r <= bus_state_nxt;
            waitreq_r <= (bus_state_nxt != orbt_pkg::ORBT_BUS_ACK);
            if (bus_state_r == orbt_pkg::ORBT_BUS_IDLE && bus_go
                && avs_read) begin
                readdata_r <= readdata_nxt;
            end
        end
    end

    // control register and sticky overrun, set wins over clear
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            log_en_r <= orbt_pkg::CTRL_LOG_EN_RST;
        end else if (ctrl_wr) begin
            log_en_r <= avs_writedata[orbt_pkg::CTRL_LOG_EN_BIT];
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            ovr_r <= 1'b0;
        end else if (log_en_r && ((a_cap && pend_a_v_r && !take_a)
                     || (b_cap && pend_b_v_r && !take_b))) begin
            ovr_r <= 1'b1;
        end else if (clr_ovr) begin
            ovr_r <= 1'b0;
        end
    end

    // capture log: one pending slot per side, stalled by the fifo
    assign take_a = pend_a_v_r && fifo_in_ready;
    assign take_b = pend_b_v_r && !pend_a_v_r && fifo_in_ready;
    assign fifo_in_valid = pend_a_v_r || pend_b_v_r;
    assign fifo_in = pend_a_v_r ? pend_a_r : pend_b_r;

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            pend_a_v_r <= 1'b0;
            pend_a_r <= '0;
        end else if (log_en_r && a_cap && (!pend_a_v_r || take_a)) begin
            pend_a_v_r <= 1'b1;
            pend_a_r <= '{side_b: 1'b0, data: a_in};
        end else if (take_a) begin
            pend_a_v_r <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            pend_b_v_r <= 1'b0;
            pend_b_r <= '0;
        end else if (log_en_r && b_cap && (!pend_b_v_r || take_b)) begin
            pend_b_v_r <= 1'b1;
            pend_b_r <= '{side_b: 1'b1, data: b_in};
        end else if (take_b) begin
            pend_b_v_r <= 1'b0;
        end
    end

    orbt_fifo #(
        .WIDTH($bits(orbt_pkg::orbt_log_t)),
        .DEPTH(orbt_pkg::FIFO_DEPTH),
        .AW(orbt_pkg::FIFO_PTR_W),
        .CW(orbt_pkg::FIFO_CNT_W)
    ) u_log_fifo (
        .clk_sys(clk_sys),
        .resetn(resetn),
        .in_valid(fifo_in_valid),
        .in_ready(fifo_in_ready),
        .in_data(fifo_in),
        .out_valid(fifo_out_valid),
        .out_ready(fifo_pop),
        .out_data(fifo_out),
        .out_settled(fifo_settled),
        .count(fifo_count),
        .full(fifo_full),
        .empty(fifo_empty)
    );

    // checks
    b_drive_en_a: assert property (@(posedge clk_sys)
        disable iff (!resetn) 1'b1 |=> b_oe == $past(b_side_drive_enable))
        else $error("port b enable does not track its pin");

    a_drive_en_a: assert property (@(posedge clk_sys)
        disable iff (!resetn) 1'b1 |=> a_oe != $past(a_side_drive_enable_low))
        else $error("port a enable does not track its low pin");

    b_live_path_a: assert property (@(posedge clk_sys)
        disable iff (!resetn) (b_side_drive_enable && !b_side_source_select)
        |=> b_oe && b_out == $past(a_in))
        else $error("port b does not follow live port a");

    a_live_path_a: assert property (@(posedge clk_sys)
        disable iff (!resetn)
        (!a_side_drive_enable_low && !a_side_source_select)
        |=> a_oe && a_out == $past(b_in))
        else $error("port a does not follow live port b");

    b_stored_path_a: assert property (@(posedge clk_sys)
        disable iff (!resetn)
        (b_side_drive_enable && b_side_source_select && a_loaded_r)
        |=> b_out == a_storage_register)
        else $error("port b does not show the a register");

    a_stored_path_a: assert property (@(posedge clk_sys)
        disable iff (!resetn)
        (!a_side_drive_enable_low && a_side_source_select && b_loaded_r)
        |=> a_out == b_storage_register)
        else $error("port a does not show the b register");

    a_capture_shown_a: assert property (@(posedge clk_sys)
        disable iff (!resetn)
        (a_rise && b_side_drive_enable && b_side_source_select)
        |=> b_out == $past(a_in) && a_storage_register == $past(a_in))
        else $error("new a capture not shown on port b");

    b_capture_a: assert property (@(posedge clk_sys)
        disable iff (!resetn) b_rise |=> b_storage_register == $past(b_in))
        else $error("b register missed its capture edge");

    a_hold_a: assert property (@(posedge clk_sys)
        disable iff (!resetn) (a_loaded_r && !a_rise && !sw_cap_a)
        |=> $stable(a_storage_register))
        else $error("a register changed without a capture");

    both_stored_a: assert property (@(posedge clk_sys)
        disable iff (!resetn) (b_side_drive_enable && !a_side_drive_enable_low
         && b_side_source_select && a_side_source_select && !a_rise
         && !b_rise && !sw_cap_a && !sw_cap_b && a_loaded_r && b_loaded_r)
        |=> a_oe && b_oe && b_out == $past(a_storage_register)
            && a_out == $past(b_storage_register))
        else $error("dual stored drive not presented");
endmodule

// ### orbt_bus_model.sv
`timescale 1ns/10ps
module orbt_bus_model (
    // clock
    input wire logic clk_sys,
    // device side
    input wire logic [7:0] a_out,
    input wire logic a_oe,
    input wire logic [7:0] b_out,
    input wire logic b_oe,
    // far side drivers
    input wire logic [7:0] a_val,
    input wire logic a_drv,
    input wire logic [7:0] b_val,
    input wire logic b_drv,
    // resolved wires
    output logic [7:0] a_wire,
    output logic [7:0] b_wire
);
    logic [7:0] a_last_r;
    logic [7:0] b_last_r;

    // device drive wins; a floating wire drifts off its last level
    always_comb begin
        a_wire = a_oe ? a_out : (a_drv ? a_val : ~a_last_r);
        b_wire = b_oe ? b_out : (b_drv ? b_val : ~b_last_r);
    end

    // last wire level, for the floating case
    always_ff @(posedge clk_sys) begin
        a_last_r <= a_wire;
        b_last_r <= b_wire;
    end
endmodule

// ### orbt_xcvr_bench.sv
`timescale 1ns/10ps
module orbt_xcvr_bench;
    logic clk_sys;
    logic resetn;
    logic [7:0] a_in, a_out, b_in, b_out;
    logic a_oe, b_oe;
    orbt_pkg::orbt_ctl_t ctl;
    logic cap_a, cap_b;
    logic [7:0] avs_address;
    logic avs_read, avs_write, avs_waitrequest;
    logic [31:0] avs_writedata, avs_readdata;
    logic [3:0] avs_byteenable;
    logic [7:0] a_val, b_val;
    logic a_drv, b_drv;
    logic [31:0] rd_q[$];
    int failures;
    int cmp_count;
    logic [7:0] xa, xb, za, zb, w;
    logic [7:0] log_d[16];

    orbt_xcvr orbt_xcvr_inst (
        .clk_sys(clk_sys), .resetn(resetn),
        .a_in(a_in), .a_out(a_out), .a_oe(a_oe),
        .b_in(b_in), .b_out(b_out), .b_oe(b_oe),
        .b_side_drive_enable(ctl.b_en),
        .a_side_drive_enable_low(ctl.a_en_n),
        .b_side_source_select(ctl.b_sel),
        .a_side_source_select(ctl.a_sel),
        .a_register_capture_clock(cap_a),
        .b_register_capture_clock(cap_b),
        .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest)
    );

    orbt_bus_model orbt_bus_model_inst (
        .clk_sys(clk_sys), .a_out(a_out), .a_oe(a_oe),
        .b_out(b_out), .b_oe(b_oe), .a_val(a_val), .a_drv(a_drv),
        .b_val(b_val), .b_drv(b_drv), .a_wire(a_in), .b_wire(b_in)
    );

    initial begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end

    task automatic chk(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic close_out();
        $display("failures %0d comparisons %0d", failures, cmp_count);
        if (failures == 0 && cmp_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys);
    endtask

    // one avalon transfer, held until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [7:0] addr,
                       input logic [31:0] d);
        int k;
        @(posedge clk_sys);
        avs_address <= addr;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= !wr;
        k = 0;
        do begin
            @(posedge clk_sys);
            k++;
        end while (avs_waitrequest !== 1'b0 && k < 50);
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        if (k >= 50) begin
            failures++;
            $display("CHECK FAILED waitrequest expected 0 seen 1");
        end
    endtask

    task automatic rd(input logic [7:0] addr, input logic [31:0] exp);
        rd_q.push_back(exp);
        bus(1'b0, addr, 32'h0000_0000);
    endtask

    // pulse capture clocks: low, high two samples, low again
    task automatic cap(input logic ea, input logic eb);
        @(posedge clk_sys);
        cap_a <= ea;
        cap_b <= eb;
        cyc(2);
        cap_a <= 1'b0;
        cap_b <= 1'b0;
        cyc(1);
    endtask

    // read data taken at the completing edge, against the oldest note
    always @(posedge clk_sys) begin
        if (avs_read === 1'b1 && avs_waitrequest === 1'b0) begin
            if (rd_q.size() == 0) begin
                failures++;
                $display("CHECK FAILED readdata expected none seen %h",
                         avs_readdata);
            end else begin
                chk("readdata", rd_q.pop_front(), avs_readdata);
            end
        end
    end

    initial begin
        #(8 * 5000);
        failures++;
        $display("watchdog expired");
        close_out();
    end

    initial begin
        failures = 0;
        cmp_count = 0;
        resetn = 1'b0;
        ctl = 4'b0100;
        cap_a = 1'b0;
        cap_b = 1'b0;
        a_val = 8'h00;
        b_val = 8'hFF;
        a_drv = 1'b1;
        b_drv = 1'b1;
        avs_address = 8'h00;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0000_0000;
        avs_byteenable = 4'hF;
        cyc(10);
        resetn <= 1'b1;
        void'($urandom(57608));
        cyc(2);
        chk("a_oe", 32'h0, a_oe);
        chk("b_oe", 32'h0, b_oe);
        // isolation, selects random
        xa = 8'($urandom);
        xb = 8'($urandom);
        ctl <= {2'b01, 2'($urandom)};
        a_val <= xa;
        b_val <= xb;
        cap(1'b1, 1'b1);
        a_val <= ~xa;
        b_val <= ~xb;
        cyc(3);
        chk("a_oe", 32'h0, a_oe);
        chk("b_oe", 32'h0, b_oe);
        rd(orbt_pkg::OFS_A_STORE, {24'h0, xa});
        rd(orbt_pkg::OFS_B_STORE, {24'h0, xb});
        // b driven from live a, then from the a register
        w = 8'($urandom);
        ctl <= 4'b1100;
        b_drv <= 1'b0;
        a_val <= w;
        cyc(3);
        chk("b_oe", 32'h1, b_oe);
        chk("b_out", {24'h0, w}, b_out);
        a_val <= ~w;
        cyc(3);
        chk("b_out", {24'h0, ~w}, b_out);
        ctl <= 4'b1110;
        cyc(3);
        chk("b_out", {24'h0, xa}, b_out);
        za = 8'($urandom);
        a_val <= za;
        cap(1'b1, 1'b0);
        chk("b_out", {24'h0, za}, b_out);
        // a driven from live b, then from the b register
        ctl <= 4'b0000;
        a_drv <= 1'b0;
        b_drv <= 1'b1;
        b_val <= w;
        cyc(3);
        chk("a_oe", 32'h1, a_oe);
        chk("b_oe", 32'h0, b_oe);
        chk("a_out", {24'h0, w}, a_out);
        ctl <= 4'b0001;
        cyc(3);
        chk("a_out", {24'h0, xb}, a_out);
        zb = 8'($urandom);
        b_val <= zb;
        cap(1'b0, 1'b1);
        chk("a_out", {24'h0, zb}, a_out);
        // both driven from the registers
        ctl <= 4'b1011;
        b_drv <= 1'b0;
        cyc(3);
        chk("b_out", {24'h0, za}, b_out);
        chk("a_out", {24'h0, zb}, a_out);
        cap(1'b1, 1'b0);
        chk("b_out", {24'h0, zb}, b_out);
        // live a to b, stored in both registers
        ctl <= 4'b1100;
        a_drv <= 1'b1;
        w = 8'($urandom);
        a_val <= w;
        cyc(3);
        cap(1'b1, 1'b1);
        rd(orbt_pkg::OFS_A_STORE, {24'h0, w});
        rd(orbt_pkg::OFS_B_STORE, {24'h0, w});
        // both driven with selects low: the loop keeps what it holds
        ctl <= 4'b1000;
        cyc(1);
        a_drv <= 1'b0;
        cyc(3);
        chk("a_out", {24'h0, w}, a_out);
        chk("b_out", {24'h0, w}, b_out);
        rd(orbt_pkg::OFS_STATUS, 32'h0000_0067);
        // capture log filled to full, then drained
        ctl <= 4'b0100;
        b_drv <= 1'b1;
        a_drv <= 1'b1;
        bus(1'b1, orbt_pkg::OFS_CTRL, 32'h0000_0001);
        rd(orbt_pkg::OFS_CTRL, 32'h0000_0001);
        for (int i = 0; i < 16; i++) begin
            log_d[i] = 8'($urandom);
            a_val <= log_d[i];
            cap(1'b1, 1'b0);
        end
        rd(orbt_pkg::OFS_STATUS, 32'h0000_1068);
        // software captures into a full log: one waits, one overruns
        za = 8'($urandom);
        zb = 8'($urandom);
        a_val <= za;
        bus(1'b1, orbt_pkg::OFS_CTRL, 32'h0000_0003);
        a_val <= zb;
        bus(1'b1, orbt_pkg::OFS_CTRL, 32'h0000_0003);
        rd(orbt_pkg::OFS_A_STORE, {24'h0, zb});
        rd(orbt_pkg::OFS_STATUS, 32'h0000_1078);
        for (int i = 0; i < 16; i++) begin
            rd(orbt_pkg::OFS_LOG, {24'h800000, log_d[i]});
        end
        rd(orbt_pkg::OFS_LOG, {24'h800000, za});
        rd(orbt_pkg::OFS_LOG, 32'h0000_0000);
        rd(orbt_pkg::OFS_STATUS, 32'h0000_0074);
        bus(1'b1, orbt_pkg::OFS_CTRL, 32'h0000_0009);
        rd(orbt_pkg::OFS_STATUS, 32'h0000_0064);
        bus(1'b1, 8'h20, 32'hFFFF_FFFF);
        rd(8'h20, 32'h0000_0000);
        cyc(2);
        close_out();
    end
endmodule
